// [logic/qcse_core.sv]
// device-side completion, error and recovery logic for native queued commands
`timescale 1ns/10ps
// Function
// R1: success sends completion fis with finished tags
// R2: success keeps error flag and code zero
// R3: completion vector is final fis dword
// R4: several completions may share one fis
// R5: only successes flagged, except log abort
// R6: error before busy clear sends register fis
// R7: error after acknowledgement sends completion fis
// R8: error aborts every outstanding command
// R9: halt until log page read, then abort
// R10: log content persists until next failure
// R11: failed tag stays set until log read
// R12: log read sends all-ones completion vector
// R13: success status busy per readiness, ready one
// R14: error status ready one, error one, code
// R15: error vector zeroes only successful tags
// R16: mask ones clear host shadow bits
// R17: completion fis touches only carried registers
// R18: host compares vector against saved copy
// R19: host issues log read after error
// R20: log returns failed tag and error code
// R21: vector bit n is tag n
// R22: success completion fis has interrupt set
// R23: internal outstanding vector builds the masks; masks here come from done_mask_q, outstanding_q only follows them
module qcse_core
  import qcse_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic                cmd_accept,
  input  wire logic [TAG_W-1:0]    cmd_tag,
  input  wire logic                cmd_unacked,
  output logic                     cmd_allowed,
  input  wire logic                done_ok,
  input  wire logic [TAG_W-1:0]    done_tag,
  input  wire logic                err_event,
  input  wire logic [TAG_W-1:0]    err_tag,
  input  wire logic [7:0]          err_code,
  input  wire logic                log_read,
  input  wire logic [7:0]          log_page,
  input  wire logic                ready_for_cmd,
  output logic                     fis_valid,
  input  wire logic                fis_ready,
  output logic [7:0]               fis_type_q,
  output logic                     fis_irq_q,
  output logic [7:0]               status_byte_reg,
  output logic [7:0]               error_code_reg,
  output logic [31:0]              tag_completion_vector,
  output logic [31:0]              fis_dw0,
  output logic                     log_valid_q,
  output logic [TAG_W-1:0]         log_tag_q,
  output logic [7:0]               log_error_q,
  output logic                     halted,
  output logic [31:0]              outstanding_q
);
  qcse_state_e                 state_q;
  qcse_state_e                 state_d;
  logic [31:0]                 done_mask_q;
  logic [31:0]                 done_mask_d;
  logic                        fis_pend_q;
  logic [31:0]                 done_bit;
  logic [31:0]                 accept_bit;
  logic [31:0]                 err_bit;
  logic [31:0]                 carry_vec;
  logic [31:0]                 err_vec;
  logic [7:0]                  ok_status;
  logic [7:0]                  err_status;
  logic [7:0]                  abort_status;
  logic                        in_run;
  logic                        err_hit;
  logic                        fis_take;
  logic                        log_hit;
  logic                        send_ok;
  logic                        err_sdb;
  logic                        log_load;

  assign in_run      = (state_q == QCSE_RUN);
  assign err_hit     = err_event && in_run;

  // one decoder per tag: vector bit n always belongs to tag n
  for (genvar t = 0; t < VEC_W; t++) begin : g_tag
    assign done_bit[t]   = done_ok && in_run && (done_tag == TAG_W'(t)); // R21
    assign accept_bit[t] = cmd_accept && cmd_allowed && (cmd_tag == TAG_W'(t)); // R21
    assign err_bit[t]    = (err_tag == TAG_W'(t)); // R21
  end

  assign log_hit     = log_read && (log_page == LOG_PAGE_NCQ) && (state_q != QCSE_ABORT);
  assign fis_take    = fis_pend_q && fis_ready;
  assign fis_valid   = fis_pend_q;
  // aggregate successes while a fis waits; no new success image starts until it drains
  assign send_ok     = !fis_pend_q && in_run && !err_event && done_mask_q != VEC_NONE; // R1 R4
  assign err_sdb     = !cmd_unacked; // R7
  assign cmd_allowed = in_run; // R9
  assign halted      = !in_run;
  assign fis_dw0     = {status_byte_reg[7:0] & 8'h77, error_code_reg, 1'b0, fis_irq_q, 6'h00, fis_type_q};

  // a success image still waiting would vanish under the error image, so its tags ride along
  assign carry_vec    = (fis_pend_q && !fis_take) ? tag_completion_vector : VEC_NONE;
  // a register fis carries no vector; its finished tags go out with the log read's all-ones mask
  assign err_vec      = err_sdb ? ((done_mask_q | done_bit | carry_vec) & ~err_bit) : VEC_NONE; // R11 R15
  assign ok_status    = (8'(!ready_for_cmd) << ST_BUSY) | (8'h01 << ST_READY); // R13
  assign err_status   = (8'h01 << ST_READY) | (8'h01 << ST_ERR); // R14
  assign abort_status = (8'h01 << ST_READY); // R13
  assign log_load     = err_hit && (outstanding_q != VEC_NONE); // R10
  // once an error or abort image has reported them, old successes must not be sent again
  assign done_mask_d  = (err_hit || log_hit) ? VEC_NONE : (send_ok ? done_bit : (done_mask_q | done_bit)); // R5

  always_comb begin
    state_d = state_q;
    case (state_q)
      QCSE_RUN: begin
        if (err_event) begin
          state_d = QCSE_HALT; // R6 R7
        end else if (log_hit) begin
          state_d = QCSE_ABORT; // R12
        end
      end
      QCSE_HALT:  if (log_hit) state_d = QCSE_ABORT; // R9
      QCSE_ABORT: if (fis_take) state_d = QCSE_RUN;
      default:    state_d = QCSE_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= QCSE_RUN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // successes collected since the last notification, only from completed tags
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done_mask_q <= VEC_NONE;
    end else if (clk_en) begin
      done_mask_q <= done_mask_d; // R5 R15
    end
  end

  // tags set on acceptance, cleared as their completion or abort is sent
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      outstanding_q <= VEC_NONE;
    end else if (clk_en) begin
      if (state_q == QCSE_ABORT && fis_take) begin
        outstanding_q <= accept_bit; // R8 R12
      end else if (send_ok) begin
        outstanding_q <= (outstanding_q & ~done_mask_q) | accept_bit; // R23
      end else if (err_event && state_q == QCSE_RUN) begin
        outstanding_q <= (outstanding_q & ~done_mask_q & ~done_bit) | accept_bit; // R15
      end else begin
        outstanding_q <= outstanding_q | accept_bit;
      end
    end
  end

  // fis image held in flip-flops until the link takes it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fis_pend_q            <= 1'b0;
      fis_type_q            <= FIS_SDB;
      fis_irq_q             <= 1'b0;
      status_byte_reg       <= STATUS_RST;
      error_code_reg        <= ERR_NONE;
      tag_completion_vector <= VEC_NONE;
    end else if (clk_en) begin
      if (err_event && state_q == QCSE_RUN) begin
        // an error overrides a pending success image; in a completion fis its successes go along in the mask
        fis_pend_q            <= 1'b1;
        fis_type_q            <= err_sdb ? FIS_SDB : FIS_REG_D2H; // R6 R7
        fis_irq_q             <= 1'b1;
        status_byte_reg       <= err_status; // R14
        error_code_reg        <= err_code; // R14
        tag_completion_vector <= err_vec; // R11 R15
      end else if (log_hit) begin
        fis_pend_q            <= 1'b1;
        fis_type_q            <= FIS_SDB;
        fis_irq_q             <= 1'b1;
        status_byte_reg       <= abort_status; // R13
        error_code_reg        <= ERR_NONE;
        tag_completion_vector <= VEC_ALL; // R12 R16
      end else if (send_ok) begin
        fis_pend_q            <= 1'b1;
        fis_type_q            <= FIS_SDB; // R17
        fis_irq_q             <= 1'b1; // R22
        status_byte_reg       <= ok_status; // R13 R2
        error_code_reg        <= ERR_NONE; // R2
        tag_completion_vector <= done_mask_q; // R1 R3
      end else if (fis_take) begin
        fis_pend_q <= 1'b0;
      end
    end
  end

  // failure record kept until another queued command fails
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      log_valid_q <= 1'b0;
      log_tag_q   <= '0;
      log_error_q <= ERR_NONE;
    end else if (clk_en) begin
      if (log_load) begin
        log_valid_q <= 1'b1; // R10
        log_tag_q   <= err_tag; // R20
        log_error_q <= err_code; // R20
      end
    end
  end
endmodule

// [logic/qcse_pkg.sv]
// package: constants for the queued command status and error block
package qcse_pkg;
  localparam int unsigned TAG_W        = 5;
  localparam int unsigned VEC_W        = 32;
  localparam logic [7:0]  FIS_SDB      = 8'ha1;
  localparam logic [7:0]  FIS_REG_D2H  = 8'h34;
  localparam logic [7:0]  LOG_PAGE_NCQ = 8'h10;
  // status byte bit positions
  localparam int unsigned ST_BUSY      = 7;
  localparam int unsigned ST_READY     = 6;
  localparam int unsigned ST_FAULT     = 5;
  localparam int unsigned ST_DREQ      = 3;
  localparam int unsigned ST_ERR       = 0;
  localparam logic [7:0]  ERR_NONE     = 8'h00;
  localparam logic [7:0]  STATUS_RST   = 8'h40;
  localparam logic [31:0] VEC_ALL      = 32'hffffffff;
  localparam logic [31:0] VEC_NONE     = 32'h00000000;
  // interrupt flag position in the first fis dword
  localparam int unsigned FIS_I_BIT    = 14;
  typedef enum logic [1:0] {QCSE_RUN, QCSE_HALT, QCSE_ABORT} qcse_state_e;
endpackage

// [test/qcse_core_monitor.sv]
// checker: error, halt and recovery timing of the queued command block
`timescale 1ns/10ps
module qcse_core_monitor
  import qcse_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             err_event,
  input wire logic             cmd_unacked,
  input wire logic             cmd_allowed,
  input wire logic             fis_valid,
  input wire logic             fis_ready,
  input wire logic             fis_irq_q,
  input wire logic             halted,
  input wire logic             log_read,
  input wire logic             ready_for_cmd,
  input wire logic [7:0]       log_page,
  input wire logic [7:0]       err_code,
  input wire logic [7:0]       fis_type_q,
  input wire logic [7:0]       status_byte_reg,
  input wire logic [7:0]       error_code_reg,
  input wire logic [TAG_W-1:0] err_tag,
  input wire logic [31:0]      tag_completion_vector,
  input wire logic [31:0]      fis_dw0,
  input wire logic [31:0]      outstanding_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_err; err_event && cmd_allowed; endsequence
  sequence s_log_hit; log_read && log_page == LOG_PAGE_NCQ && halted && !fis_valid; endsequence
  err_sdb_a: assert property (s_err ##0 !cmd_unacked |=> fis_type_q == FIS_SDB && fis_valid
    && (status_byte_reg & 8'he9) == 8'h41 && error_code_reg == $past(err_code)) else $error("error sdb bad");
  err_reg_a: assert property (s_err ##0 cmd_unacked |=> fis_valid && fis_type_q == FIS_REG_D2H
    && status_byte_reg[ST_ERR] && !status_byte_reg[ST_BUSY]) else $error("error register fis bad");
  halt_on_err_a: assert property (s_err |=> halted && !cmd_allowed) else $error("no halt");
  failed_kept_a: assert property (s_err ##0 !cmd_unacked |=> !tag_completion_vector[$past(err_tag)])
    else $error("failed tag in mask");
  abort_mask_a: assert property (s_log_hit |=> fis_valid && tag_completion_vector == VEC_ALL)
    else $error("abort mask bad");
  ok_status_a: assert property (fis_valid && fis_type_q == FIS_SDB && !status_byte_reg[ST_ERR]
    && tag_completion_vector != VEC_ALL |-> fis_irq_q && error_code_reg == ERR_NONE
    && (status_byte_reg & 8'h69) == 8'h40) else $error("success status bad");
  dw0_map_a: assert property (fis_valid |-> fis_dw0[7:0] == fis_type_q && fis_dw0[23:16] == error_code_reg
    && fis_dw0[31:24] == (status_byte_reg & 8'h77) && fis_dw0[FIS_I_BIT] == fis_irq_q) else $error("dw0 bad");
  recover_run_a: assert property (fis_valid && fis_ready && halted && tag_completion_vector == VEC_ALL
    |=> cmd_allowed && outstanding_q == VEC_NONE) else $error("no recovery");
  busy_map_a: assert property (fis_valid && !$past(fis_valid) && fis_type_q == FIS_SDB && !status_byte_reg[ST_ERR]
    && tag_completion_vector != VEC_ALL |-> status_byte_reg[ST_BUSY] == !$past(ready_for_cmd))
    else $error("success busy bad");
endmodule
bind qcse_core qcse_core_monitor qcse_core_monitor_i (.*);

// [test/qcse_host_model.sv]
// host partner: takes each fis, stalls at random when slow, keeps the shadow tag vector
`timescale 1ns/10ps
module qcse_host_model
  import qcse_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             fis_valid,
  input wire logic             issue,
  input wire logic             slow,
  input wire logic [7:0]       fis_type_q,
  input wire logic [TAG_W-1:0] issue_tag,
  input wire logic [31:0]      tag_completion_vector,
  output logic                 fis_ready,
  output logic [31:0]          shadow
);
  wire take = fis_valid && fis_ready && fis_type_q == FIS_SDB;
  always_ff @(posedge core_clk) begin
    fis_ready <= resetn && (!slow || $urandom % 2 == 1);
    // ones clear, zeros keep; a register fis leaves the vector alone
    if (!resetn) shadow <= VEC_NONE;
    else shadow <= (shadow & ~(take ? tag_completion_vector : VEC_NONE)) | (32'(issue) << issue_tag);
  end
endmodule

// [test/qcse_core_tb_top.sv]
// testbench: random completions, error halt and log recovery of the queued command block
`timescale 1ns/10ps
module qcse_core_tb_top;
  import qcse_pkg::*;
  logic core_clk = 0, resetn = 0, cmd_accept = 0, cmd_unacked = 0, done_ok = 0, err_event = 0, log_read = 0, slow = 0;
  logic ready_for_cmd = 1;
  logic [31:0] prev_v;
  logic [TAG_W-1:0] cmd_tag = '0, done_tag = '0, err_tag = '0;
  logic [7:0] err_code = '0, log_page = '0, fis_type_q, status_byte_reg, error_code_reg, log_error_q;
  logic cmd_allowed, fis_valid, fis_ready, fis_irq_q, log_valid_q, halted;
  logic [TAG_W-1:0] log_tag_q;
  logic [31:0] tag_completion_vector, fis_dw0, outstanding_q, shadow, exp_v, done_v;
  int errors = 0, comparisons = 0;
  always #5 core_clk = ~core_clk;
  qcse_core qcse_core_i (.core_clk, .resetn, .clk_en(1'b1), .cmd_accept, .cmd_tag, .cmd_unacked, .cmd_allowed,
    .done_ok, .done_tag, .err_event, .err_tag, .err_code, .log_read, .log_page, .ready_for_cmd, .fis_valid,
    .fis_ready, .fis_type_q, .fis_irq_q, .status_byte_reg, .error_code_reg, .tag_completion_vector, .fis_dw0,
    .log_valid_q, .log_tag_q, .log_error_q, .halted, .outstanding_q);
  qcse_host_model qcse_host_model_i (.core_clk, .resetn, .fis_valid, .issue(cmd_accept && cmd_allowed), .slow,
    .fis_type_q, .issue_tag(cmd_tag), .tag_completion_vector, .fis_ready, .shadow);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // tags the host still holds: issued minus reported successes
  function automatic logic [31:0] left_open(logic [31:0] issued, logic [31:0] done);
    return issued & ~done;
  endfunction
  // one quiet cycle after each pulse so back-to-back calls never rewrite a strobe in one step
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge core_clk) s = 0;
    @(negedge core_clk);
  endtask
  // a follow-on fis may rise right after one is taken, so wait for three quiet cycles
  task automatic drain();
    int q = 0;
    for (int i = 0; i < 200 && q < 3; i++) begin
      @(negedge core_clk) q = fis_valid ? 0 : q + 1;
    end
    if (q < 3) begin
      errors++;
      wrap_up();
    end
  endtask
  initial begin
    void'($urandom(41));
    repeat (5) @(negedge core_clk);
    resetn = 1;
    check("status", status_byte_reg, STATUS_RST);
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      exp_v = $urandom() | 32'h80000001;
      for (int t = 0; t < 32; t++) if (exp_v[t]) begin
        cmd_tag = t[4:0];
        pulse(cmd_accept);
      end
      done_v = exp_v & $urandom() & 32'h7ffffffe;
      prev_v = shadow;
      for (int t = 0; t < 32; t++) if (done_v[t]) begin
        done_tag = t[4:0];
        ready_for_cmd = 1'($urandom());
        pulse(done_ok);
      end
      drain();
      check("shadow", shadow, left_open(exp_v, done_v));
      check("new done", prev_v & ~shadow, done_v);
      check("outstanding", outstanding_q, left_open(exp_v, done_v));
      err_tag = k[0] ? 5'h00 : 5'h1f;
      err_code = 8'($urandom_range(255, 1));
      cmd_unacked = k[0];
      pulse(err_event);
      cmd_unacked = 0;
      drain();
      check("shadow err", shadow, exp_v & ~done_v);
      cmd_tag = 5'h05;
      pulse(cmd_accept);
      check("refused", outstanding_q[5], exp_v[5] & ~done_v[5]);
      log_page = 8'h11;
      pulse(log_read);
      drain();
      check("halt", {halted, cmd_allowed}, 2'b10);
      log_page = LOG_PAGE_NCQ;
      for (int r = 0; r < 2; r++) begin
        pulse(log_read);
        drain();
        check("log", {log_valid_q, log_tag_q, log_error_q}, {1'b1, err_tag, err_code});
        check("shadow log", shadow, VEC_NONE);
        check("run", cmd_allowed, 1);
      end
    end
    wrap_up();
  end
endmodule
